// ===== src/cab_pkg.sv
// Package with register map, reset values, counts and carrier types of the enhance/balance register slice
// What this block does
// RL1: Two fixed identity bytes, high then low
// RL2: Doubling bit: 704-clock line, data twice
// RL3: Bit 5 enables first aperture stage
// RL4: Bit 4 enables second aperture stage
// RL5: Smart mode drops pixels outside luminance band
// RL6: Smart and stop need balance and auto
// RL7: Stop freezes balance on dark frames
// RL8: Fast mode updates gains every frame
// RL9: Slow mode updates every 16 or 64
// RL10: First 1024 frames fast, then slow
// RL11: Bit 0 doubles output drive current
// RL12: Monochrome variant: balance bits not programmable
// RL13: Writes to read-only registers are ignored
package cab_pkg;

  // ---------------------------------------------
  // Register offsets
  // ---------------------------------------------
  localparam logic [7:0] ADDR_MAKER_HIGH = 8'h1C;
  localparam logic [7:0] ADDR_MAKER_LOW = 8'h1D;
  localparam logic [7:0] ADDR_RSVD_1E = 8'h1E;
  localparam logic [7:0] ADDR_RSVD_1F = 8'h1F;
  localparam logic [7:0] ADDR_CTRL = 8'h20;

  // ---------------------------------------------
  // Reset and fixed read values
  // ---------------------------------------------
  localparam logic [7:0] RST_RSVD_1E = 8'hC4;
  localparam logic [7:0] RST_RSVD_1F = 8'h04;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // Bits 3..1 of the control register, locked on the monochrome variant
  localparam logic [7:0] MONO_LOCK_MASK = 8'h0E;

  // ---------------------------------------------
  // Counts
  // ---------------------------------------------
  localparam int LINE_DBL_CLKS = 704;
  localparam int FAST_FRAMES = 1024;
  localparam int SLOW_SHORT = 16;
  localparam int SLOW_LONG = 64;
  localparam int SYNC_STAGES = 2;

  // ---------------------------------------------
  // Carrier types
  // ---------------------------------------------
  typedef struct packed {
    logic line_dbl;
    logic rsvd;
    logic ap1_en;
    logic ap2_en;
    logic smart;
    logic stop;
    logic fast;
    logic drive_dbl;
  } cab_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [7:0] luma;
    logic [7:0] data;
  } cab_pix_t;

  typedef struct packed {
    logic stb;
    logic [7:0] addr;
    logic [7:0] data;
  } cab_wr_t;

endpackage

// ===== src/cab_serial_slave.sv
// Two-wire serial control slave: start/stop, device address, subaddress, byte writes and reads
`timescale 1ns/1ns
module cab_serial_slave
  import cab_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h30
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Synchronised bus lines
  input wire logic scl_s,
  input wire logic sda_s,
  // Data line drive (open drain, low only)
  output logic sda_oe_r,
  // Register port
  output cab_wr_t wr_r,
  output logic [7:0] sub_r,
  input wire logic [7:0] rd_data
);

  typedef enum logic [2:0] {S_IDLE, S_DEV, S_SUB, S_WR, S_ACK, S_RD, S_RACK, S_RNEXT} cab_sstate_t;

  cab_sstate_t state_r, nxt_r;
  logic scl_d, sda_d;
  logic [2:0] cnt_r;
  logic [7:0] sh_r;

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c = scl_s & scl_d & ~sda_d & sda_s;
  wire [7:0] byte_in = {sh_r[6:0], sda_s};
  wire byte_done = scl_rise & (cnt_r == 3'h7);
  wire rx_state = (state_r == S_DEV) | (state_r == S_SUB) | (state_r == S_WR);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      nxt_r <= S_IDLE;
      cnt_r <= 3'h0;
      sh_r <= 8'h00;
      sda_oe_r <= 1'b0;
      wr_r <= '0;
      sub_r <= 8'h00;
    end else begin
      wr_r.stb <= 1'b0;
      if (start_c) begin
        state_r <= S_DEV;
        cnt_r <= 3'h0;
        sda_oe_r <= 1'b0;
      end else if (stop_c) begin
        state_r <= S_IDLE;
        sda_oe_r <= 1'b0;
      end else if (rx_state & scl_rise) begin
        sh_r <= byte_in;
        cnt_r <= cnt_r + 3'h1;
        if (byte_done) begin
          state_r <= S_ACK;
          unique case (state_r)
            S_DEV: begin
              if (byte_in[7:1] != DEV_ADDR) begin
                state_r <= S_IDLE;
              end
              nxt_r <= byte_in[0] ? S_RD : S_SUB;
            end
            S_SUB: begin
              sub_r <= byte_in;
              nxt_r <= S_WR;
            end
            default: begin
              wr_r <= '{stb: 1'b1, addr: sub_r, data: byte_in};
              sub_r <= sub_r + 8'h01;
              nxt_r <= S_WR;
            end
          endcase
        end
      end else if (scl_fall) begin
        unique case (state_r)
          S_ACK: begin
            if (!sda_oe_r) begin
              sda_oe_r <= 1'b1;
            end else begin
              state_r <= nxt_r;
              cnt_r <= 3'h0;
              sda_oe_r <= 1'b0;
              if (nxt_r == S_RD) begin
                sh_r <= rd_data;
                sda_oe_r <= ~rd_data[7];
              end
            end
          end
          S_RD: begin
            cnt_r <= cnt_r + 3'h1;
            sh_r <= {sh_r[6:0], 1'b0};
            sda_oe_r <= ~sh_r[6];
            if (cnt_r == 3'h7) begin
              sda_oe_r <= 1'b0;
              state_r <= S_RACK;
            end
          end
          S_RNEXT: begin
            sh_r <= rd_data;
            sda_oe_r <= ~rd_data[7];
            cnt_r <= 3'h0;
            state_r <= S_RD;
          end
          default: begin
          end
        endcase
      end else if ((state_r == S_RACK) & scl_rise) begin
        if (!sda_s) begin
          sub_r <= sub_r + 8'h01;
          state_r <= S_RNEXT;
        end else begin
          state_r <= S_IDLE;
        end
      end
    end
  end

endmodule

// ===== src/cab_regs.sv
// Identity bytes, enhance/balance control register and the logic it steers
`timescale 1ns/1ns
module cab_regs
  import cab_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h30,
  // Arbitrary identity values, not any real maker's codes
  parameter logic [7:0] MAKER_HIGH = 8'h5A,
  parameter logic [7:0] MAKER_LOW = 8'h3C,
  parameter bit MONO = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial control pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Settings held in neighbouring registers
  input wire logic awb_enable,
  input wire logic auto_enable,
  input wire logic [2:0] gamma_level,
  input wire logic slow_long_sel,
  input wire logic [7:0] aperture1_level,
  input wire logic [3:0] aperture2_level,
  input wire logic [7:0] luma_band,
  // Video timing and pixels
  input wire logic frame_start,
  input wire logic line_valid_in,
  input cab_pix_t pix_in,
  // Video out
  output logic line_valid,
  output logic pix_out_valid,
  output logic [7:0] pix_out,
  // Enhancement, balance and drive controls
  output logic ap1_on,
  output logic [7:0] ap1_strength,
  output logic ap2_on,
  output logic [3:0] ap2_strength,
  output logic awb_pix_use,
  output logic awb_update,
  output logic awb_frozen,
  output logic drive_double
);

  // ---------------------------------------------
  // Reset release and pin synchronisers
  // ---------------------------------------------
  logic [SYNC_STAGES-1:0] rst_sync_r;
  logic [SYNC_STAGES-1:0] scl_sync_r, sda_sync_r;
  wire rst_n = rst_sync_r[SYNC_STAGES-1];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_r <= '0;
    end else begin
      rst_sync_r <= {rst_sync_r[SYNC_STAGES-2:0], 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_r <= '1;
      sda_sync_r <= '1;
    end else begin
      scl_sync_r <= {scl_sync_r[SYNC_STAGES-2:0], scl};
      sda_sync_r <= {sda_sync_r[SYNC_STAGES-2:0], sda_in};
    end
  end

  // ---------------------------------------------
  // Serial slave and register file
  // ---------------------------------------------
  cab_wr_t wr;
  logic [7:0] sub;
  logic [7:0] rd_data;
  cab_ctrl_t ctrl_r;

  cab_serial_slave #(.DEV_ADDR(DEV_ADDR)) u_slave (
    .clk(clk),
    .rst_n(rst_n),
    .scl_s(scl_sync_r[SYNC_STAGES-1]),
    .sda_s(sda_sync_r[SYNC_STAGES-1]),
    .sda_oe_r(sda_oe),
    .wr_r(wr),
    .sub_r(sub),
    .rd_data(rd_data)
  );

  wire ctrl_we = wr.stb & (wr.addr == ADDR_CTRL);
  wire [7:0] ctrl_wval = MONO ? (wr.data & ~MONO_LOCK_MASK) : wr.data; // [RL12]

  assign rd_data = (sub == ADDR_MAKER_HIGH) ? MAKER_HIGH : // [RL1]
                   (sub == ADDR_MAKER_LOW) ? MAKER_LOW : // [RL1]
                   (sub == ADDR_RSVD_1E) ? RST_RSVD_1E :
                   (sub == ADDR_RSVD_1F) ? RST_RSVD_1F :
                   (sub == ADDR_CTRL) ? ctrl_r : RD_UNMAPPED;

  // Only the control register has storage; other writes fall away
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= RST_CTRL;
      sda_out <= 1'b0;
    end else if (ctrl_we) begin // [RL13]
      ctrl_r <= ctrl_wval;
    end
  end

  // ---------------------------------------------
  // Line doubling
  // ---------------------------------------------
  logic [9:0] dbl_cnt_r;
  logic lv_d_r, rep_r;
  wire lv_rise = line_valid_in & ~lv_d_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dbl_cnt_r <= 10'h000;
      lv_d_r <= 1'b0;
      rep_r <= 1'b0;
      line_valid <= 1'b0;
      pix_out_valid <= 1'b0;
      pix_out <= 8'h00;
    end else begin
      lv_d_r <= line_valid_in;
      if (ctrl_r.line_dbl & lv_rise) begin
        dbl_cnt_r <= 10'(LINE_DBL_CLKS - 1); // [RL2]
      end else if (dbl_cnt_r != 10'h000) begin
        dbl_cnt_r <= dbl_cnt_r - 10'h001;
      end
      line_valid <= ctrl_r.line_dbl ? (lv_rise | (dbl_cnt_r != 10'h000)) : line_valid_in; // [RL2]
      rep_r <= pix_in.valid & ctrl_r.line_dbl; // [RL2]
      pix_out_valid <= pix_in.valid | rep_r;
      if (pix_in.valid) begin
        pix_out <= pix_in.data;
      end
    end
  end

  // ---------------------------------------------
  // Aperture and drive controls
  // ---------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ap1_on <= 1'b0;
      ap1_strength <= 8'h00;
      ap2_on <= 1'b0;
      ap2_strength <= 4'h0;
      drive_double <= 1'b0;
    end else begin
      ap1_on <= ctrl_r.ap1_en; // [RL3]
      ap1_strength <= ctrl_r.ap1_en ? aperture1_level : 8'h00; // [RL3]
      ap2_on <= ctrl_r.ap2_en; // [RL4]
      ap2_strength <= ctrl_r.ap2_en ? aperture2_level : 4'h0; // [RL4]
      drive_double <= ctrl_r.drive_dbl; // [RL11]
    end
  end

  // ---------------------------------------------
  // White balance pixel selection and darkness
  // ---------------------------------------------
  logic [25:0] luma_sum_r;
  logic [16:0] pix_cnt_r;
  logic [10:0] frames_r;
  logic [5:0] slow_cnt_r;

  wire awb_gate = awb_enable & auto_enable;
  wire smart_on = ctrl_r.smart & awb_gate; // [RL6]
  wire stop_on = ctrl_r.stop & awb_gate; // [RL6]
  wire [7:0] band_lo = {luma_band[3:0], 4'h0};
  wire [7:0] band_hi = {luma_band[7:4], 4'hF};
  wire in_band = (pix_in.luma >= band_lo) & (pix_in.luma <= band_hi);
  wire [25:0] dark_limit = 26'({18'h00000, gamma_level, 5'h00} * {9'h000, pix_cnt_r});
  wire dark_now = luma_sum_r < dark_limit;
  wire fast_on = ctrl_r.fast | (frames_r < 11'(FAST_FRAMES)); // [RL10]
  wire [5:0] slow_last = slow_long_sel ? 6'(SLOW_LONG - 1) : 6'(SLOW_SHORT - 1); // [RL9]
  wire slow_hit = slow_cnt_r >= slow_last;
  wire freeze = stop_on & dark_now; // [RL7]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      luma_sum_r <= 26'h0000000;
      pix_cnt_r <= 17'h00000;
      awb_pix_use <= 1'b0;
    end else begin
      awb_pix_use <= pix_in.valid & (~smart_on | in_band); // [RL5]
      if (frame_start) begin
        luma_sum_r <= 26'h0000000;
        pix_cnt_r <= 17'h00000;
      end else if (pix_in.valid) begin
        luma_sum_r <= luma_sum_r + 26'(pix_in.luma);
        pix_cnt_r <= pix_cnt_r + 17'h00001;
      end
    end
  end

  // ---------------------------------------------
  // Gain update scheduling
  // ---------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frames_r <= 11'h000;
      slow_cnt_r <= 6'h00;
      awb_update <= 1'b0;
      awb_frozen <= 1'b0;
    end else begin
      awb_update <= 1'b0;
      if (!awb_enable) begin
        frames_r <= 11'h000; // [RL10]
        slow_cnt_r <= 6'h00;
        awb_frozen <= 1'b0;
      end else if (frame_start) begin
        awb_frozen <= freeze; // [RL7]
        if (frames_r < 11'(FAST_FRAMES)) begin
          frames_r <= frames_r + 11'h001;
        end
        slow_cnt_r <= slow_hit ? 6'h00 : slow_cnt_r + 6'h01;
        awb_update <= ~freeze & (fast_on | slow_hit); // [RL8] [RL9]
      end
    end
  end

endmodule

// ===== sim/cab_regs_sva.sv
// Port checker of the enhance/balance register slice
`timescale 1ns/1ns
module cab_regs_sva
  import cab_pkg::*;
(
  // Clock and reset
  input wire logic clk, nrst,
  // Settings and video in
  input wire logic awb_enable, auto_enable, frame_start, line_valid_in,
  input wire logic [7:0] aperture1_level,
  input wire cab_pix_t pix_in,
  // Outputs watched
  input wire logic line_valid, pix_out_valid, ap1_on, ap2_on, awb_pix_use, awb_update, awb_frozen,
  input wire logic [7:0] ap1_strength,
  input wire logic [3:0] ap2_strength
);
  logic [10:0] run_r;
  // Length of the current output line
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_r <= 11'h000;
    end else begin
      run_r <= line_valid ? run_r + 11'h001 : 11'h000;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  ap1_level_a: assert property (ap1_on && $stable(aperture1_level) |-> ap1_strength == aperture1_level)
    else $error("aperture one strength wrong");
  ap1_off_a: assert property (!ap1_on |-> ap1_strength == 8'h00)
    else $error("aperture one strength while off");
  ap2_off_a: assert property (!ap2_on |-> ap2_strength == 4'h0)
    else $error("aperture two strength while off");
  update_cause_a: assert property (awb_update |-> $past(frame_start) && $past(awb_enable))
    else $error("gain update without frame start");
  update_pulse_a: assert property (awb_update |=> !awb_update)
    else $error("gain update longer than one cycle");
  update_frozen_a: assert property (awb_update |-> !awb_frozen)
    else $error("gain update while frozen");
  freeze_gate_a: assert property ($rose(awb_frozen) |-> $past(frame_start && awb_enable && auto_enable))
    else $error("freeze without enables");
  freeze_hold_a: assert property (!$past(frame_start) && $past(awb_enable) |-> $stable(awb_frozen))
    else $error("freeze changed inside a frame");
  frozen_clear_a: assert property (!$past(awb_enable) |-> !awb_frozen)
    else $error("freeze held while balance disabled");
  pix_cause_a: assert property ($rose(pix_out_valid) |-> $past(pix_in.valid))
    else $error("output pixel without input pixel");
  line_len_a: assert property ($fell(line_valid) |-> run_r == 11'h2C0 || $past(line_valid_in, 2) && !$past(line_valid_in))
    else $error("line length wrong");
  use_cause_a: assert property (awb_pix_use |-> $past(pix_in.valid))
    else $error("balance pixel without input pixel");
  cover property (awb_update);
  cover property ($rose(awb_frozen));
  cover property ($fell(line_valid) && run_r == 11'h2C0);
endmodule

bind cab_regs cab_regs_sva u_sva (.*);

// ===== sim/cab_host.sv
// Host controller model on the two-wire serial control pins
`timescale 1ns/1ns
module cab_host #(
  parameter logic [6:0] DEV = 7'h30,
  parameter int Q = 12
) (
  // Clock
  input wire logic clk,
  // Serial lines, data line pulled up
  output logic scl,
  output wire logic sda,
  input wire logic dev_oe
);
  logic low_r;
  logic [7:0] rq[$];
  assign sda = !(low_r || dev_oe);
  initial begin
    scl = 1'b1;
    low_r = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One bit: drive b (1 releases), sample line while clock high
  task automatic xbit(input logic b, output logic r);
    low_r = !b;
    w(Q);
    scl = 1'b1;
    w(Q);
    r = sda;
    w(Q);
    scl = 1'b0;
    w(Q);
  endtask
  task automatic xbyte(input logic [7:0] d, input logic ab, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
    xbit(ab, a);
  endtask
  task automatic start();
    low_r = 1'b0;
    scl = 1'b1;
    w(Q);
    low_r = 1'b1;
    w(Q);
    scl = 1'b0;
    w(Q);
  endtask
  task automatic stop();
    low_r = 1'b1;
    w(Q);
    scl = 1'b1;
    w(Q);
    low_r = 1'b0;
    w(2 * Q);
  endtask
  task automatic reg_wr(input logic [7:0] sub, input logic [7:0] d);
    logic [7:0] r;
    start();
    xbyte({DEV, 1'b0}, 1'b1, r);
    xbyte(sub, 1'b1, r);
    xbyte(d, 1'b1, r);
    stop();
  endtask
  // Set subaddress, then read n bytes, last one not acknowledged
  task automatic reg_rd(input logic [7:0] sub, input int n);
    logic [7:0] r;
    start();
    xbyte({DEV, 1'b0}, 1'b1, r);
    xbyte(sub, 1'b1, r);
    stop();
    start();
    xbyte({DEV, 1'b1}, 1'b1, r);
    for (int k = 0; k < n; k++) begin
      xbyte(8'hFF, k == n - 1, r);
      rq.push_back(r);
    end
    stop();
  endtask
endmodule

// ===== sim/tb_camera_id_and_awb_enhance_regs.sv
// Self-checking bench of the enhance/balance register slice
`timescale 1ns/1ns
module tb_camera_id_and_awb_enhance_regs
  import cab_pkg::*;
;
  // Arbitrary identity values
  localparam logic [7:0] MH = 8'h5A;
  localparam logic [7:0] ML = 8'h3C;
  logic clk, nrst, awb_enable, auto_enable, slow_long_sel, frame_start, line_valid_in, ov, ov2, use_s;
  logic [2:0] gamma_level;
  logic [7:0] aperture1_level, luma_band, v, po;
  logic [3:0] aperture2_level;
  logic [31:0] seed;
  cab_pix_t pix_in;
  wire scl, sda_in, sda_out, sda_oe, line_valid, pix_out_valid, ap1_on, ap2_on;
  wire awb_pix_use, awb_update, awb_frozen, drive_double;
  wire [7:0] pix_out, ap1_strength;
  wire [3:0] ap2_strength;
  wire scl_m, sda_m, sda_oe_m;
  int mismatches, num_checks, cyc, u;

  cab_regs #(.MAKER_HIGH(MH), .MAKER_LOW(ML)) dut (.*);
  cab_host host (.clk(clk), .scl(scl), .sda(sda_in), .dev_oe(sda_oe));
  // Monochrome variant with its own host
  cab_regs #(.MAKER_HIGH(MH), .MAKER_LOW(ML), .MONO(1'b1)) dut_mono (.*, .scl(scl_m), .sda_in(sda_m), .sda_out(),
    .sda_oe(sda_oe_m), .line_valid(), .pix_out_valid(), .pix_out(), .ap1_on(), .ap1_strength(), .ap2_on(),
    .ap2_strength(), .awb_pix_use(), .awb_update(), .awb_frozen(), .drive_double());
  cab_host host_m (.clk(clk), .scl(scl_m), .sda(sda_m), .dev_oe(sda_oe_m));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      $display("[FAIL] t=%0t cycles %h limit %h", $time, cyc, 90000);
      stop_test();
    end
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic exp_use(input logic [7:0] l, input logic [7:0] b, input logic sm);
    return !sm || (l >= {b[3:0], 4'h0} && l <= {b[7:4], 4'hF});
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rd_chk(input logic [7:0] sub, input int n, input logic [47:0] e);
    host.rq.delete();
    host.reg_rd(sub, n);
    for (int i = 0; i < n; i++) chk(host.rq[i], e[47 - 8 * i -: 8]);
  endtask
  task automatic pixel(input logic [7:0] d, input logic [7:0] l);
    pix_in = {1'b1, l, d};
    w(1);
    pix_in.valid = 1'b0;
    {use_s, ov, po} = {awb_pix_use, pix_out_valid, pix_out};
    w(1);
    ov2 = pix_out_valid;
    w(1);
  endtask
  task automatic frames(input int n, output int c);
    c = 0;
    repeat (n) begin
      frame_start = 1'b1;
      w(1);
      frame_start = 1'b0;
      repeat (3) begin
        c += awb_update;
        w(1);
      end
    end
  endtask
  task automatic line(output int n);
    n = 0;
    line_valid_in = 1'b1;
    for (int i = 0; i < 800; i++) begin
      if (i == 10) line_valid_in = 1'b0;
      w(1);
      n += line_valid;
    end
  endtask
  task automatic done(input string s);
    $display("test %s done, checks %0d", s, num_checks);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    seed = 32'hF28248F4;
    {nrst, awb_enable, slow_long_sel, frame_start, line_valid_in, gamma_level} = '0;
    {aperture1_level, aperture2_level, pix_in} = '0;
    auto_enable = 1'b1;
    luma_band = 8'h84;
    w(2);
    nrst = 1'b1;
    w(6);
    rd_chk(ADDR_MAKER_HIGH, 6, {MH, ML, RST_RSVD_1E, RST_RSVD_1F, RST_CTRL, RD_UNMAPPED});
    chk(sda_out, 1'b0);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      host.reg_wr(ADDR_MAKER_HIGH + 8'(i), seed[7:0]);
    end
    rd_chk(ADDR_MAKER_HIGH, 5, {MH, ML, RST_RSVD_1E, RST_RSVD_1F, RST_CTRL, 8'h00});
    done("identity");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      v = i == 0 ? 8'h7F : {1'b0, seed[6:0]};
      {aperture1_level, aperture2_level} = seed[19:8];
      host.reg_wr(ADDR_CTRL, v);
      rd_chk(ADDR_CTRL, 1, {v, 40'h0});
      chk(drive_double, v[0]);
      chk({ap1_on, ap2_on}, v[5:4]);
      chk(ap1_strength, v[5] ? aperture1_level : 8'h00);
      chk(ap2_strength, v[4] ? aperture2_level : 4'h0);
    end
    done("control");
    host_m.reg_wr(ADDR_CTRL, 8'h7F);
    host_m.rq.delete();
    host_m.reg_rd(ADDR_CTRL, 1);
    chk(host_m.rq[0], 8'h71);
    done("mono");
    awb_enable = 1'b1;
    for (int m = 0; m < 3; m++) begin
      host.reg_wr(ADDR_CTRL, m != 0 ? 8'h08 : 8'h00);
      auto_enable = m != 2;
      for (int k = 0; k < 6; k++) begin
        seed = xs(seed);
        v = k < 4 ? 8'(32'h3F408F90 >> (24 - 8 * k)) : seed[23:16];
        pixel(seed[7:0], v);
        chk(use_s, exp_use(v, luma_band, m == 1));
        chk({ov, ov2, po}, {2'b10, seed[7:0]});
      end
    end
    done("smart");
    host.reg_wr(ADDR_CTRL, 8'h80);
    pixel(8'hA5, 8'h00);
    chk({ov, ov2, po}, {2'b11, 8'hA5});
    line(u);
    chk(16'(u), 16'(LINE_DBL_CLKS));
    host.reg_wr(ADDR_CTRL, 8'h00);
    line(u);
    chk(16'(u), 16'h000A);
    done("doubling");
    host.reg_wr(ADDR_CTRL, 8'h06);
    for (int m = 0; m < 3; m++) begin
      auto_enable = m != 2;
      gamma_level = m == 1 ? 3'h1 : 3'h7;
      frames(1, u);
      repeat (4) pixel(8'h00, m == 1 ? 8'hFF : 8'h00);
      frames(1, u);
      chk({awb_frozen, u[0]}, m == 0 ? 2'b10 : 2'b01);
    end
    done("stop");
    host.reg_wr(ADDR_CTRL, 8'h00);
    awb_enable = 1'b0;
    w(2);
    awb_enable = 1'b1;
    frames(FAST_FRAMES - 24, u);
    chk(16'(u), 16'(FAST_FRAMES - 24));
    frames(30, u);
    frames(2 * SLOW_SHORT, u);
    chk(16'(u), 16'h0002);
    slow_long_sel = 1'b1;
    frames(SLOW_LONG, u);
    frames(2 * SLOW_LONG, u);
    chk(16'(u), 16'h0002);
    host.reg_wr(ADDR_CTRL, 8'h02);
    frames(20, u);
    chk(16'(u), 16'h0014);
    done("rate");
    stop_test();
  end
endmodule
